// [hdl/dbh_port.sv]
// Double-buffered handshake port pair with status flags and register port.
// Assumes pins arrive asynchronously and the register master obeys one-cycle strobes.
`timescale 1ns/1ps
module dbh_port
  import dbh_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic [4:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic [7:0] i_port_a,
  input  wire logic [7:0] i_port_b,
  output logic      [7:0] o_port_a,
  output logic      [7:0] o_port_a_oe,
  output logic      [7:0] o_port_b,
  output logic      [7:0] o_port_b_oe,
  input  wire logic       i_strobe_a,
  input  wire logic       i_handshake_a,
  input  wire logic       i_strobe_b,
  input  wire logic       i_handshake_b,
  output logic            o_handshake_out_a,
  output logic            o_handshake_out_a_oe,
  output logic            o_handshake_out_b,
  output logic            o_handshake_out_b_oe
);

  dbh_state_t  st_r;
  dbh_state_t  st_nxt;
  logic [1:0]  mode;
  logic        wide;
  logic [3:0]  sense;
  logic [1:0]  en;
  logic [3:0]  asr;
  logic [3:0]  asr_prev;
  logic [3:0]  hedge;
  logic [1:0]  is_in;
  logic [1:0]  is_out;
  logic [1:0]  ibp;
  logic [1:0]  obp;
  logic [1:0]  sub;
  logic [2:0]  hs;
  logic        hshk;
  logic        hin;
  logic        taken;
  logic        hi_byte;
  logic        x;
  logic        ip;
  logic        op;
  logic [15:0] cap;
  logic [7:0]  rbyte;

  always_comb
  begin
    st_nxt   = st_r;
    mode     = st_r.gcr_r[GCR_MODE_HI:GCR_MODE_LO];
    wide     = (mode == MODE_U16) || (mode == MODE_B16);
    sense    = st_r.gcr_r[GCR_SENSE_HI:0];
    en       = st_r.gcr_r[GCR_EN_B:GCR_EN_A];
    // Asserted when the level matches the sense bit
    asr      = ~(st_r.s2_r[HS_PIN0+:4] ^ sense);
    asr_prev = ~(st_r.hprev_r ^ sense);
    hedge    = asr & ~asr_prev;
    sub      = 2'h0;
    hs       = 3'h0;
    hshk     = 1'b0;
    hin      = 1'b0;
    taken    = 1'b0;
    cap      = 16'h0000;
    rbyte    = 8'h00;
    x        = (i_addr == ADDR_DATA_B);
    hi_byte  = wide && !x;
    ip       = (mode == MODE_U8) ? x : 1'b1;
    op       = (mode == MODE_U8) ? x : (mode == MODE_U16);

    // Two-flop synchronisers; edges are taken from the second stage only
    st_nxt.s1_r    = {i_handshake_b, i_strobe_b, i_handshake_a, i_strobe_a,
                      i_port_b, i_port_a};
    st_nxt.s2_r    = st_r.s1_r;
    st_nxt.hprev_r = st_r.s2_r[HS_PIN0+:4];

    for (int p = 0; p < 2; p++)
    begin
      sub = st_r.pcr_r[p][PCR_SUB_HI:PCR_SUB_LO];
      unique case (mode)
        MODE_U8:
        begin
          is_in[p]  = (sub == 2'h0);
          is_out[p] = (sub == 2'h1);
        end
        MODE_U16:
        begin
          is_in[p]  = (p == 1) && !sub[0];
          is_out[p] = (p == 1) && sub[0];
        end
        default:
        begin
          // Bidirectional: first pair steers output, second pair input
          is_in[p]  = (p == 1);
          is_out[p] = (p == 0);
        end
      endcase
    end

    for (int q = 0; q < 2; q++)
    begin
      if (mode == MODE_U8)
      begin
        ibp[q] = is_in[q];
        obp[q] = is_out[q];
      end
      else if (mode == MODE_U16)
      begin
        ibp[q] = is_in[1];
        obp[q] = is_out[1];
      end
      else
      begin
        ibp[q] = (mode == MODE_B16) || (q == 1);
        obp[q] = (mode == MODE_B16) || (q == 1);
      end
    end

    // Register reads; a data read of the last byte frees one input slot
    if (i_rd)
    begin
      unique case (i_addr)
        ADDR_GCR:   rbyte = st_r.gcr_r;
        ADDR_DDR_A: rbyte = st_r.ddr_r[0];
        ADDR_DDR_B: rbyte = st_r.ddr_r[1];
        ADDR_PCR_A: rbyte = st_r.pcr_r[0];
        ADDR_PCR_B: rbyte = st_r.pcr_r[1];
        ADDR_ALT_A: rbyte = st_r.s2_r[7:0];
        ADDR_ALT_B: rbyte = st_r.s2_r[15:8];
        ADDR_STAT:  rbyte = {st_r.s2_r[HS_PIN0+:4], st_r.flag_r};
        ADDR_DATA_A, ADDR_DATA_B:
        begin
          if (ibp[x])
          begin
            rbyte = hi_byte ? st_r.ib_r[ip][0][15:8] : st_r.ib_r[ip][0][7:0];
            if (!hi_byte && st_r.icnt_r[ip] != 2'h0)
            begin
              st_nxt.ib_r[ip][0] = st_r.ib_r[ip][1];
              st_nxt.icnt_r[ip]  = st_r.icnt_r[ip] - 2'h1;
            end
          end
          else
          begin
            rbyte = (st_r.ddr_r[x] & st_r.oreg_r[x]) |
                    (~st_r.ddr_r[x] & st_r.s2_r[8*x+:8]);
          end
        end
        default:    rbyte = 8'h00;
      endcase
      st_nxt.rdata_r = rbyte;
    end

    if (i_wr)
    begin
      unique case (i_addr)
        ADDR_GCR:   st_nxt.gcr_r    = i_wdata;
        ADDR_DDR_A: st_nxt.ddr_r[0] = i_wdata;
        ADDR_DDR_B: st_nxt.ddr_r[1] = i_wdata;
        ADDR_PCR_A: st_nxt.pcr_r[0] = i_wdata;
        ADDR_PCR_B: st_nxt.pcr_r[1] = i_wdata;
        // Non-resettable flags are rebuilt below, so the mask only sticks where allowed
        ADDR_STAT:  st_nxt.flag_r   = st_r.flag_r & ~i_wdata[3:0];
        default:    ;
      endcase
    end

    for (int p = 0; p < 2; p++)
    begin
      hs    = st_r.pcr_r[p][PCR_HS_HI:PCR_HS_LO];
      hshk  = (hs == HS_LOCK) || (hs == HS_PULSE);
      hin   = !hs[2];
      taken = 1'b0;
      cap   = wide ? {st_r.s2_r[7:0], st_r.s2_r[15:8]} : {8'h00, st_r.s2_r[8*p+:8]};

      // Set is applied after the mask clear, so a same-cycle edge survives
      if (!hin)
        st_nxt.flag_r[2*p+1] = 1'b0;
      else if (hedge[2*p+1])
        st_nxt.flag_r[2*p+1] = 1'b1;

      if (!en[p])
      begin
        st_nxt.icnt_r[p]     = 2'h0;
        st_nxt.ocnt_r[p]     = 2'h0;
        st_nxt.armed_r[p]    = 1'b0;
        st_nxt.dly_r[p]      = 2'h0;
        st_nxt.pcnt_r[p]     = 3'h0;
        st_nxt.flag_r[2*p]   = 1'b0;
        st_nxt.flag_r[2*p+1] = 1'b0;
      end
      else if (is_in[p])
      begin
        // In interlocked or pulsed modes, strobes are ignored while the handshake is not armed
        if (hedge[2*p] && st_nxt.icnt_r[p] != BUF_DEPTH && (!hshk || st_r.armed_r[p]))
        begin
          st_nxt.ib_r[p][st_nxt.icnt_r[p][0]] = cap;
          st_nxt.icnt_r[p]  = st_nxt.icnt_r[p] + 2'h1;
          st_nxt.armed_r[p] = 1'b0;
          taken             = 1'b1;
        end
        if (hshk && !st_r.armed_r[p] && !taken && st_nxt.icnt_r[p] != BUF_DEPTH)
        begin
          st_nxt.armed_r[p] = 1'b1;
          st_nxt.pcnt_r[p]  = 3'h0;
        end
        st_nxt.flag_r[2*p] = (st_nxt.icnt_r[p] != 2'h0);
      end
      else if (is_out[p])
      begin
        if (hedge[2*p] && st_r.ocnt_r[p] != 2'h0 && (!hshk || st_r.armed_r[p]))
        begin
          st_nxt.ob_r[p][0] = st_r.ob_r[p][1];
          st_nxt.ocnt_r[p]  = st_r.ocnt_r[p] - 2'h1;
          st_nxt.armed_r[p] = 1'b0;
          st_nxt.dly_r[p]   = 2'h0;
          taken             = 1'b1;
        end
        else if (st_r.ocnt_r[p] == 2'h0)
        begin
          st_nxt.dly_r[p] = 2'h0;
        end
        else if (hshk && !st_r.armed_r[p])
        begin
          // Data has settled on the pins for two cycles before the pin asserts
          if (st_r.dly_r[p] == PRESENT_DLY - 2'h1)
          begin
            st_nxt.armed_r[p] = 1'b1;
            st_nxt.pcnt_r[p]  = 3'h0;
          end
          else
          begin
            st_nxt.dly_r[p] = st_r.dly_r[p] + 2'h1;
          end
        end
        if (st_r.pcr_r[p][PCR_STAT])
          st_nxt.flag_r[2*p] = (st_nxt.ocnt_r[p] == 2'h0);
        else
          st_nxt.flag_r[2*p] = (st_nxt.ocnt_r[p] != BUF_DEPTH);
      end
      else
      begin
        st_nxt.armed_r[p] = 1'b0;
        if (hedge[2*p])
          st_nxt.flag_r[2*p] = 1'b1;
      end

      if (st_nxt.armed_r[p] && st_r.armed_r[p] && st_r.pcnt_r[p] != PULSE_CYC)
        st_nxt.pcnt_r[p] = st_r.pcnt_r[p] + 3'h1;

      unique case (hs)
        HS_NEG:   st_nxt.h2o_r[p] = 1'b0;
        HS_ASRT:  st_nxt.h2o_r[p] = 1'b1;
        HS_LOCK:  st_nxt.h2o_r[p] = st_nxt.armed_r[p];
        // Pulse ends after four cycles or earlier when a strobe takes it
        HS_PULSE: st_nxt.h2o_r[p] = st_nxt.armed_r[p] &&
                                    st_nxt.pcnt_r[p] != PULSE_CYC;
        default:  st_nxt.h2o_r[p] = 1'b0;
      endcase
      st_nxt.h2o_r[p]  = sense[2*p+1] ? st_nxt.h2o_r[p] : !st_nxt.h2o_r[p];
      st_nxt.h2oe_r[p] = !hin;
    end

    // Writes after the strobe pop, so a full buffer freed this cycle accepts data
    if (i_wr && (i_addr == ADDR_DATA_A || i_addr == ADDR_DATA_B))
    begin
      if (!obp[x])
        st_nxt.oreg_r[x] = i_wdata;
      else if (hi_byte)
        st_nxt.stage_r = i_wdata;
      else if (en[op] && st_nxt.ocnt_r[op] != BUF_DEPTH)
      begin
        st_nxt.ob_r[op][st_nxt.ocnt_r[op][0]] = {wide ? st_r.stage_r : 8'h00, i_wdata};
        st_nxt.ocnt_r[op] = st_nxt.ocnt_r[op] + 2'h1;
      end
    end

    for (int q = 0; q < 2; q++)
    begin
      if (obp[q])
        st_nxt.pout_r[q] = (wide && q == 0) ? st_nxt.ob_r[op][0][15:8]
                                            : st_nxt.ob_r[(mode == MODE_U8) ? q : op][0][7:0];
      else
        st_nxt.pout_r[q] = st_nxt.oreg_r[q];
      // Bidirectional drivers follow the output strobe level
      if (mode == MODE_B16 || (mode == MODE_B8 && q == 1))
        st_nxt.poe_r[q] = {8{asr[0]}};
      else
        st_nxt.poe_r[q] = st_r.ddr_r[q];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_rdata              = st_r.rdata_r;
  assign o_port_a             = st_r.pout_r[0];
  assign o_port_a_oe          = st_r.poe_r[0];
  assign o_port_b             = st_r.pout_r[1];
  assign o_port_b_oe          = st_r.poe_r[1];
  assign o_handshake_out_a    = st_r.h2o_r[0];
  assign o_handshake_out_a_oe = st_r.h2oe_r[0];
  assign o_handshake_out_b    = st_r.h2o_r[1];
  assign o_handshake_out_b_oe = st_r.h2oe_r[1];

endmodule

// [hdl/dbh_pkg.sv]
// Constants, register map and state record for the double-buffered handshake port.
// Assumes a single 200 MHz core clock and a plain strobe-style register port.
// How it works
// - Unidirectional modes: each pin direction follows its own direction register bit.
// - Primary direction is double-buffered with handshake; the other is a plain path.
// - Bidirectional modes ignore direction registers except port A in mode 2.
// - Bit I/O: no double buffering; handshake pins are outputs or status inputs.
// - Input data is captured on the asserted strobe edge.
// - Input strobe flag is 1 while unread data sits in the input latches.
// - Edge-input second pin sets its flag; mask write, reset or disable clears.
// - General-output second pin is fixed negated or asserted; its flag reads 0.
// - Interlocked input: pin asserted while room exists, strobes ignored while negated.
// - Pulsed input: same condition, asserted four cycles at most, ended by a strobe.
// - Pair disabled: interlocked or pulsed second pin is held negated.
// - Output strobe flag shows room, or with its control bit all data sent.
// - Edge-input second pin during output sets its flag; same clearing.
// - Interlocked output: pin asserted two cycles after data enters the latch.
// - Strobes while the output pin is negated leave data; they still drive enables.
// - Pulsed output: interlocked condition, at most four cycles, cut by a strobe.
// - Sense bits 3..0 of general control set pin polarity; 0 means low.
// - Resettable flags clear only where software writes a 1.
// - Pair disabled: its double-buffer controller is held empty.
package dbh_pkg;

  localparam logic [4:0] ADDR_GCR    = 5'h00;
  localparam logic [4:0] ADDR_DDR_A  = 5'h02;
  localparam logic [4:0] ADDR_DDR_B  = 5'h03;
  localparam logic [4:0] ADDR_PCR_A  = 5'h06;
  localparam logic [4:0] ADDR_PCR_B  = 5'h07;
  localparam logic [4:0] ADDR_DATA_A = 5'h08;
  localparam logic [4:0] ADDR_DATA_B = 5'h09;
  localparam logic [4:0] ADDR_ALT_A  = 5'h0A;
  localparam logic [4:0] ADDR_ALT_B  = 5'h0B;
  localparam logic [4:0] ADDR_STAT   = 5'h0D;

  localparam int GCR_MODE_HI  = 7;
  localparam int GCR_MODE_LO  = 6;
  localparam int GCR_EN_B     = 5;
  localparam int GCR_EN_A     = 4;
  localparam int GCR_SENSE_HI = 3;
  localparam int PCR_SUB_HI   = 7;
  localparam int PCR_SUB_LO   = 6;
  localparam int PCR_HS_HI    = 5;
  localparam int PCR_HS_LO    = 3;
  localparam int PCR_STAT     = 0;
  localparam int HS_PIN0      = 16;

  localparam logic [1:0] MODE_U8  = 2'h0;
  localparam logic [1:0] MODE_U16 = 2'h1;
  localparam logic [1:0] MODE_B8  = 2'h2;
  localparam logic [1:0] MODE_B16 = 2'h3;

  // Second-pin roles; any code with the top bit clear is an edge input
  localparam logic [2:0] HS_NEG   = 3'h4;
  localparam logic [2:0] HS_ASRT  = 3'h5;
  localparam logic [2:0] HS_LOCK  = 3'h6;
  localparam logic [2:0] HS_PULSE = 3'h7;

  localparam logic [2:0] PULSE_CYC   = 3'h4;
  localparam logic [1:0] PRESENT_DLY = 2'h2;
  localparam logic [1:0] BUF_DEPTH   = 2'h2;

  typedef struct packed {
    logic [7:0]            gcr_r;
    logic [1:0][7:0]       ddr_r;
    logic [1:0][7:0]       pcr_r;
    logic [1:0][7:0]       oreg_r;
    logic [1:0][7:0]       pout_r;
    logic [1:0][7:0]       poe_r;
    logic [7:0]            stage_r;
    logic [7:0]            rdata_r;
    logic [19:0]           s1_r;
    logic [19:0]           s2_r;
    logic [3:0]            hprev_r;
    logic [3:0]            flag_r;
    logic [1:0][1:0][15:0] ib_r;
    logic [1:0][1:0][15:0] ob_r;
    logic [1:0][1:0]       icnt_r;
    logic [1:0][1:0]       ocnt_r;
    logic [1:0][1:0]       dly_r;
    logic [1:0][2:0]       pcnt_r;
    logic [1:0]            armed_r;
    logic [1:0]            h2o_r;
    logic [1:0]            h2oe_r;
  } dbh_state_t;

endpackage

// [sim/dbh_port_sva.sv]
// Checks on the port A second pin, pin direction and status reads.
// Assumes configuration changes only through the register port.
`timescale 1ns/1ps
module dbh_port_sva
  import dbh_pkg::*;
(
  input wire logic       i_core_clk,
  input wire logic       i_rstn,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_strobe_a,
  input wire logic [7:0] o_port_a_oe,
  input wire logic       o_handshake_out_a,
  input wire logic       o_handshake_out_a_oe
);
  logic [7:0] gcr_r;
  logic [7:0] pcr_r;
  logic [7:0] ddr_r;
  logic [2:0] quiet_r;
  logic       ok;
  logic       asrt;
  logic       s_asrt;
  logic [2:0] hs;

  // A write restarts the count, so checks skip the three cycles that follow each write
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      gcr_r   <= 8'h00;
      pcr_r   <= 8'h00;
      ddr_r   <= 8'h00;
      quiet_r <= 3'h0;
    end
    else
    begin
      if (i_wr && i_addr == ADDR_GCR)
        gcr_r <= i_wdata;
      if (i_wr && i_addr == ADDR_PCR_A)
        pcr_r <= i_wdata;
      if (i_wr && i_addr == ADDR_DDR_A)
        ddr_r <= i_wdata;
      if (i_wr)
        quiet_r <= 3'h0;
      else if (quiet_r != 3'h7)
        quiet_r <= quiet_r + 3'h1;
    end
  end

  assign ok     = quiet_r >= 3'h3 && gcr_r[7:6] == MODE_U8;
  assign hs     = pcr_r[5:3];
  assign asrt   = o_handshake_out_a == gcr_r[1];
  assign s_asrt = i_strobe_a == gcr_r[0];

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  chk_off_negated:
  assert property (ok && !gcr_r[4] && hs[2:1] == 2'b11 |-> !asrt)
    else $error("second pin not negated while disabled");
  chk_fixed_neg:
  assert property (ok && hs == HS_NEG |-> !asrt && o_handshake_out_a_oe)
    else $error("fixed negated pin wrong");
  chk_fixed_asrt:
  assert property (ok && hs == HS_ASRT |-> asrt && o_handshake_out_a_oe)
    else $error("fixed asserted pin wrong");
  chk_role_flag:
  assert property (i_rd && i_addr == ADDR_STAT && ok && hs[2] |=> !o_rdata[1])
    else $error("output role flag not zero");
  chk_pulse_len:
  assert property ($rose(asrt) && ok && hs == HS_PULSE |-> ##[1:4] !asrt)
    else $error("pulse longer than four cycles");
  chk_out_assert:
  assert property (i_wr && i_addr == ADDR_DATA_A && ok && gcr_r[4] && pcr_r[7:6] == 2'b01
                   && hs == HS_LOCK && !asrt |-> ##[2:6] asrt)
    else $error("output pin not asserted after data");
  chk_in_negate:
  assert property ($rose(s_asrt) && ok && gcr_r[4] && pcr_r[7:6] == 2'b00
                   && hs == HS_LOCK && asrt |-> ##[1:6] !asrt)
    else $error("input pin not negated after strobe");
  chk_dir_follow:
  assert property (ok |-> o_port_a_oe == ddr_r)
    else $error("pin direction differs from direction register");

  cover property ($rose(asrt) && ok && hs == HS_PULSE);
  cover property ($rose(s_asrt) && ok && hs == HS_LOCK && asrt);
  cover property (i_wr && i_addr == ADDR_DATA_A && ok && pcr_r[7:6] == 2'b01);
endmodule

bind dbh_port dbh_port_sva u_sva
(
  .i_core_clk           (i_core_clk),
  .i_rstn               (i_rstn),
  .i_addr               (i_addr),
  .i_wdata              (i_wdata),
  .i_wr                 (i_wr),
  .i_rd                 (i_rd),
  .o_rdata              (o_rdata),
  .i_strobe_a           (i_strobe_a),
  .o_port_a_oe          (o_port_a_oe),
  .o_handshake_out_a    (o_handshake_out_a),
  .o_handshake_out_a_oe (o_handshake_out_a_oe)
);

// [sim/dbh_periph.sv]
// Peripheral on port A: presents a byte, then pulses the strobe low.
// Assumes sense bits 0 and a request only while o_busy is low.
`timescale 1ns/1ps
module dbh_periph
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_go,
  input  wire logic [7:0] i_data,
  input  wire logic [3:0] i_hold,
  output logic            o_strobe,
  output logic      [7:0] o_port,
  output logic            o_busy
);
  logic [4:0] cnt_r;

  assign o_busy = cnt_r != 5'h00;

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_r    <= 5'h00;
      o_strobe <= 1'b1;
      o_port   <= 8'hFF;
    end
    else if (cnt_r == 5'h00)
    begin
      o_strobe <= 1'b1;
      // Released pins float up to the pull-up level
      o_port   <= 8'hFF;
      if (i_go)
      begin
        cnt_r  <= {1'b0, i_hold} + 5'h05;
        o_port <= i_data;
      end
    end
    else
    begin
      cnt_r    <= cnt_r - 5'h01;
      o_strobe <= !(cnt_r > 5'h05);
      if (cnt_r == 5'h03)
        o_port <= 8'hFF;
    end
  end
endmodule

// [sim/test_dbh_port.sv]
// Register-level tests of the port A handshake paths.
// Assumes the peripheral model on port A; port B pins idle.
`timescale 1ns/1ps
module test_dbh_port
  import dbh_pkg::*;
();
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic       hs_in = 1'b1;
  logic       go = 1'b0;
  logic [7:0] go_data = 8'h00;
  logic [3:0] go_hold = 4'h3;
  logic [7:0] rdata, port_a, port_oe, pin_a, got, port_b, port_b_oe;
  logic       strobe_a, busy, hs_out, hs_oe, hs_b, hs_b_oe;
  int         fail_count = 0;
  int         samples_checked = 0;

  always #2.5 clk = ~clk;

  dbh_port u_dut (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_port_a(pin_a), .i_port_b(8'hFF),
    .o_port_a(port_a), .o_port_a_oe(port_oe), .o_port_b(port_b), .o_port_b_oe(port_b_oe),
    .i_strobe_a(strobe_a), .i_handshake_a(hs_in), .i_strobe_b(1'b1),
    .i_handshake_b(1'b1), .o_handshake_out_a(hs_out), .o_handshake_out_a_oe(hs_oe),
    .o_handshake_out_b(hs_b), .o_handshake_out_b_oe(hs_b_oe));
  dbh_periph u_periph (.i_core_clk(clk), .i_rstn(rstn), .i_go(go), .i_data(go_data),
    .i_hold(go_hold), .o_strobe(strobe_a), .o_port(pin_a), .o_busy(busy));

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      $display("Error at %0t: saw %h, expected %h", $time, g, e);
      fail_count++;
    end
  endtask

  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic send(input logic [7:0] d, input logic [3:0] h);
    int n;
    @(posedge clk);
    go <= 1'b1;
    go_data <= d;
    go_hold <= h;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (n = 0; n < 40 && busy; n++)
      @(posedge clk);
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(ADDR_GCR);
    chk(got, 8'h00);
    rd_reg(5'h0E);
    chk(got, 8'h00);
    // Port B second pin starts as an undriven edge input, idle negated
    chk(8'({hs_b, hs_b_oe}), 8'h02);
    $display("reset test done");
    for (int s = 0; s < 2; s++)
      for (int c = 4; c < 6; c++)
      begin
        wr_reg(ADDR_GCR, s[0] ? 8'h02 : 8'h00);
        wr_reg(ADDR_PCR_A, 8'(c << 3));
        settle();
        chk(8'(hs_out), 8'((c == 5) ? s[0] : !s[0]));
        chk(8'(hs_oe), 8'h01);
        rd_reg(ADDR_STAT);
        chk(got & 8'h02, 8'h00);
      end
    $display("fixed output test done");
    wr_reg(ADDR_GCR, 8'h00);
    wr_reg(ADDR_PCR_A, 8'h80);
    wr_reg(ADDR_DDR_A, 8'hA5);
    wr_reg(ADDR_DATA_A, 8'h3C);
    settle();
    chk(port_oe, 8'hA5);
    chk(port_a & 8'hA5, 8'h24);
    rd_reg(ADDR_DATA_A);
    chk(got, 8'h7E);
    $display("bit io test done");
    wr_reg(ADDR_DDR_A, 8'h00);
    for (int c = 6; c < 8; c++)
    begin
      wr_reg(ADDR_PCR_A, 8'(c << 3));
      wr_reg(ADDR_GCR, 8'h00);
      settle();
      chk(8'(hs_out), 8'h01);
      wr_reg(ADDR_GCR, 8'h10);
      settle();
      chk(8'(hs_out), 8'h00);
      // The pulse is in its fourth cycle here and must end at the next edge
      if (c == 7)
      begin
        @(posedge clk);
        #1;
        chk(8'(hs_out), 8'h01);
      end
      send(8'h5A, 4'h3);
      send(8'hA5, 4'h9);
      send(8'h77, 4'h3);
      settle();
      if (c == 6)
        chk(8'(hs_out), 8'h01);
      rd_reg(ADDR_STAT);
      chk(got & 8'h01, 8'h01);
      rd_reg(ADDR_DATA_A);
      chk(got, 8'h5A);
      rd_reg(ADDR_DATA_A);
      chk(got, 8'hA5);
      rd_reg(ADDR_STAT);
      chk(got & 8'h01, 8'h00);
      send(8'h11, 4'h3);
      settle();
      rd_reg(ADDR_STAT);
      chk(got & 8'h01, 8'h01);
      wr_reg(ADDR_GCR, 8'h00);
      settle();
      rd_reg(ADDR_STAT);
      chk(got & 8'h01, 8'h00);
    end
    $display("input test done");
    wr_reg(ADDR_PCR_A, 8'h00);
    wr_reg(ADDR_GCR, 8'h10);
    settle();
    @(posedge clk);
    hs_in <= 1'b0;
    settle();
    @(posedge clk);
    hs_in <= 1'b1;
    settle();
    rd_reg(ADDR_STAT);
    chk(got & 8'h02, 8'h02);
    wr_reg(ADDR_STAT, 8'h00);
    rd_reg(ADDR_STAT);
    chk(got & 8'h02, 8'h02);
    wr_reg(ADDR_STAT, 8'h02);
    rd_reg(ADDR_STAT);
    chk(got & 8'h02, 8'h00);
    $display("edge flag test done");
    wr_reg(ADDR_DDR_A, 8'hFF);
    wr_reg(ADDR_PCR_A, 8'h70);
    settle();
    rd_reg(ADDR_STAT);
    chk(got & 8'h01, 8'h01);
    wr_reg(ADDR_DATA_A, 8'hC3);
    wr_reg(ADDR_DATA_A, 8'h3C);
    settle();
    rd_reg(ADDR_STAT);
    chk(got & 8'h01, 8'h00);
    chk(port_a, 8'hC3);
    chk(8'(hs_out), 8'h00);
    send(8'h00, 4'h3);
    settle();
    chk(port_a, 8'h3C);
    chk(8'(hs_out), 8'h00);
    rd_reg(ADDR_STAT);
    chk(got & 8'h01, 8'h01);
    wr_reg(ADDR_PCR_A, 8'h71);
    settle();
    rd_reg(ADDR_STAT);
    chk(got & 8'h01, 8'h00);
    send(8'h00, 4'h5);
    settle();
    rd_reg(ADDR_STAT);
    chk(got & 8'h01, 8'h01);
    $display("output test done");
    wr_reg(ADDR_PCR_A, 8'h40);
    settle();
    @(posedge clk);
    hs_in <= 1'b0;
    settle();
    @(posedge clk);
    hs_in <= 1'b1;
    settle();
    rd_reg(ADDR_STAT);
    chk(got & 8'h02, 8'h02);
    wr_reg(ADDR_GCR, 8'h00);
    settle();
    rd_reg(ADDR_STAT);
    chk(got & 8'h02, 8'h00);
    $display("output edge flag test done");
    wr_reg(ADDR_DDR_B, 8'hFF);
    wr_reg(ADDR_PCR_B, 8'h70);
    wr_reg(ADDR_GCR, 8'h60);
    wr_reg(ADDR_DATA_A, 8'h12);
    wr_reg(ADDR_DATA_B, 8'h34);
    settle();
    chk(port_a, 8'h12);
    chk(port_b, 8'h34);
    chk(port_b_oe, 8'hFF);
    chk(8'({hs_b, hs_b_oe}), 8'h01);
    rd_reg(ADDR_STAT);
    chk(got & 8'h04, 8'h04);
    $display("wide output test done");
    wr_reg(ADDR_GCR, 8'hB0);
    settle();
    chk(port_oe, 8'hFF);
    chk(port_b_oe, 8'h00);
    wr_reg(ADDR_GCR, 8'hF0);
    settle();
    chk(port_oe, 8'h00);
    $display("bidirectional test done");
    test_done();
  end
endmodule
